// *** tb/tb.sv ***
// self-checking bench for the secure stream table configuration block
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
module tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic regSecure = 1'b1;
   logic [sst_cfg_pkg::REG_ADDR_W-1:0] regAddr = 16'h0000;
   logic [31:0] regWdata = 32'h0;
   logic regReadValid;
   logic [31:0] regRdata;
   logic [31:0] rdata2;
   logic translationEnable = 1'b0;
   logic secureEnableAck = 1'b0;
   logic recordInvalidIdEnable = 1'b0;
   logic lookupValid = 1'b0;
   logic [15:0] lookupId = 16'h0000;
   logic lookupDone, lookupAbort, badStreamEvent, readAllocHint, twoLevelLookup;
   logic [51:0] fetchAddr;
   logic [15:0] l2Index;
   logic [5:0] l1CountLog2;
   logic [31:0] lastRd2;
   logic [4:0] splitCode [4] = '{5'h06, 5'h08, 5'h0A, 5'h07};
   logic [51:0] expAddr [4] = '{52'h12338, 52'h12348, 52'h12340, 52'h12338};
   logic [15:0] expL2 [4] = '{16'h0005, 16'h00C5, 16'h01C5, 16'h0005};
   logic [5:0] expCnt [4] = '{6'h04, 6'h02, 6'h00, 6'h04};
   int errors = 0;
   int num_checks = 0;
   // ------------------------------------------------------------
   // design instances
   // ------------------------------------------------------------
   secure_stream_table_config i_dut (
      .clk(clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
      .regSecure(regSecure), .regAddr(regAddr), .regWdata(regWdata),
      .regReadValid(regReadValid), .regRdata(regRdata),
      .translationEnable(translationEnable), .secureEnableAck(secureEnableAck),
      .recordInvalidIdEnable(recordInvalidIdEnable), .lookupValid(lookupValid),
      .lookupId(lookupId), .lookupDone(lookupDone), .lookupAbort(lookupAbort),
      .badStreamEvent(badStreamEvent), .readAllocHint(readAllocHint),
      .twoLevelLookup(twoLevelLookup), .fetchAddr(fetchAddr), .l2Index(l2Index),
      .l1CountLog2(l1CountLog2)
   );
   // single-level build, only its readback is watched
   secure_stream_table_config #(.MULTI_LEVEL(1'b0)) i_dut2 (
      .clk(clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
      .regSecure(regSecure), .regAddr(regAddr), .regWdata(regWdata),
      .regReadValid(), .regRdata(rdata2),
      .translationEnable(translationEnable), .secureEnableAck(secureEnableAck),
      .recordInvalidIdEnable(recordInvalidIdEnable), .lookupValid(lookupValid),
      .lookupId(lookupId), .lookupDone(), .lookupAbort(), .badStreamEvent(),
      .readAllocHint(), .twoLevelLookup(), .fetchAddr(), .l2Index(), .l1CountLog2()
   );
   // ------------------------------------------------------------
   // clock, verdict and watchdog
   // ------------------------------------------------------------
   initial
   begin
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      // about 125 cycles expected, ample margin
      #50000;
      errors++;
      finish_test();
   end
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [15:0] addr, input logic [31:0] data);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= addr;
      regWdata <= data;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] addr, input logic [31:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= addr;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      lastRd2 = rdata2;
      `CHK(regReadValid, 1'b1)
      `CHK(regRdata, exp)
      @(posedge clk);
   endtask
   task automatic look(input logic [15:0] id, input logic abt, input logic [51:0] adr,
                       input logic [15:0] l2, input logic [5:0] cnt, input logic two);
      @(posedge clk);
      lookupValid <= 1'b1;
      lookupId <= id;
      @(posedge clk);
      lookupValid <= 1'b0;
      #1;
      `CHK(lookupDone, 1'b1)
      `CHK(lookupAbort, abt)
      `CHK(badStreamEvent, abt & recordInvalidIdEnable)
      `CHK(fetchAddr, adr)
      `CHK(l2Index, l2)
      `CHK(l1CountLog2, cnt)
      `CHK(twoLevelLookup, two)
      @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(sst_cfg_pkg::BASE_LO_OFF, 32'h0);
      rd(sst_cfg_pkg::BASE_HI_OFF, 32'h0);
      rd(sst_cfg_pkg::LAYOUT_OFF, 32'h0);
      // field masks and reserved bits
      wr(sst_cfg_pkg::BASE_LO_OFF, 32'hFFFFFFFF);
      rd(sst_cfg_pkg::BASE_LO_OFF, 32'hFFFFFFC0);
      wr(sst_cfg_pkg::BASE_HI_OFF, 32'hFFFFFFFF);
      rd(sst_cfg_pkg::BASE_HI_OFF, 32'h400FFFFF);
      wr(sst_cfg_pkg::LAYOUT_OFF, 32'hFFFFFFFF);
      rd(sst_cfg_pkg::LAYOUT_OFF, 32'h000307FF);
      `CHK(lastRd2, 32'h0000003F)
      rd(16'h808C, 32'h0);
      // non-secure side sees nothing and changes nothing
      regSecure <= 1'b0;
      rd(sst_cfg_pkg::BASE_LO_OFF, 32'h0);
      wr(sst_cfg_pkg::BASE_LO_OFF, 32'h0);
      regSecure <= 1'b1;
      rd(sst_cfg_pkg::BASE_LO_OFF, 32'hFFFFFFC0);
      // guard by enable, then by acknowledge
      translationEnable <= 1'b1;
      wr(sst_cfg_pkg::BASE_LO_OFF, 32'h0);
      wr(sst_cfg_pkg::LAYOUT_OFF, 32'h0);
      rd(sst_cfg_pkg::BASE_LO_OFF, 32'hFFFFFFC0);
      rd(sst_cfg_pkg::LAYOUT_OFF, 32'h000307FF);
      translationEnable <= 1'b0;
      secureEnableAck <= 1'b1;
      wr(sst_cfg_pkg::BASE_HI_OFF, 32'h0);
      wr(sst_cfg_pkg::LAYOUT_OFF, 32'h0);
      rd(sst_cfg_pkg::BASE_HI_OFF, 32'h400FFFFF);
      rd(sst_cfg_pkg::LAYOUT_OFF, 32'h000307FF);
      secureEnableAck <= 1'b0;
      // linear lookups, split field present but ignored
      wr(sst_cfg_pkg::BASE_HI_OFF, 32'h40000000);
      wr(sst_cfg_pkg::BASE_LO_OFF, 32'h00012340);
      wr(sst_cfg_pkg::LAYOUT_OFF, 32'h00000284);
      recordInvalidIdEnable <= 1'b1;
      look(16'h0005, 1'b0, 52'h12140, 16'h0, 6'h0, 1'b0);
      `CHK(readAllocHint, 1'b1)
      look(16'h000F, 1'b0, 52'h123C0, 16'h0, 6'h0, 1'b0);
      look(16'h0010, 1'b1, 52'h0, 16'h0, 6'h0, 1'b0);
      recordInvalidIdEnable <= 1'b0;
      look(16'h0010, 1'b1, 52'h0, 16'h0, 6'h0, 1'b0);
      wr(sst_cfg_pkg::BASE_HI_OFF, 32'h0);
      wr(sst_cfg_pkg::LAYOUT_OFF, 32'h00030284);
      look(16'h0005, 1'b0, 52'h12140, 16'h0, 6'h0, 1'b0);
      `CHK(readAllocHint, 1'b0)
      // two-level with every split code and one reserved code
      recordInvalidIdEnable <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr(sst_cfg_pkg::LAYOUT_OFF, {14'h0, 2'h1, 5'h00, splitCode[i], 6'h0A});
         look(16'h01C5, 1'b0, expAddr[i], expL2[i], expCnt[i], 1'b1);
      end
      look(16'h0400, 1'b1, 52'h0, 16'h0, 6'h04, 1'b1);
      // split equal to size leaves one bottom table, split never above size
      wr(sst_cfg_pkg::LAYOUT_OFF, 32'h00010208);
      look(16'h00C5, 1'b0, 52'h12340, 16'h00C5, 6'h00, 1'b1);
      look(16'h0100, 1'b1, 52'h0, 16'h0, 6'h0, 1'b1);
      // oversize table: raw size aligns, capped size checks range
      wr(sst_cfg_pkg::BASE_LO_OFF, 32'h0FFFFFC0);
      wr(sst_cfg_pkg::LAYOUT_OFF, 32'h00000014);
      look(16'hFFFF, 1'b0, 52'h0C3FFFC0, 16'h0, 6'h0, 1'b0);
      rd(sst_cfg_pkg::LAYOUT_OFF, 32'h00000014);
      finish_test();
   end
endmodule // tb

// *** verilog/secure_stream_table_config.sv ***
// secure stream table configuration registers and stream lookup
`timescale 1ns/10ps
module secure_stream_table_config #(
   parameter int PA_W = 52,
   parameter int SID_W = 16,
   parameter bit MULTI_LEVEL = 1'b1,
   parameter bit SECURE_PRESENT = 1'b1,
   parameter bit TABLES_PRESET = 1'b0,
   parameter logic [63:0] PRESET_BASE = sst_cfg_pkg::BASE_RESET,
   parameter logic [31:0] PRESET_LAYOUT = sst_cfg_pkg::LAYOUT_RESET
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register access
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic regSecure,
   input wire logic [sst_cfg_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   output logic regReadValid,
   output logic [31:0] regRdata,
   // unit control
   input wire logic translationEnable,
   input wire logic secureEnableAck,
   input wire logic recordInvalidIdEnable,
   // lookup request
   input wire logic lookupValid,
   input wire logic [SID_W-1:0] lookupId,
   // lookup answer
   output logic lookupDone,
   output logic lookupAbort,
   output logic badStreamEvent,
   output logic readAllocHint,
   output logic twoLevelLookup,
   output logic [PA_W-1:0] fetchAddr,
   output logic [SID_W-1:0] l2Index,
   output logic [5:0] l1CountLog2
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   localparam int AL = sst_cfg_pkg::ADDR_LSB;
   localparam logic [5:0] SID_W6 = 6'(SID_W);
   localparam logic [PA_W-1:AL] BASE_INIT = TABLES_PRESET ? PRESET_BASE[PA_W-1:AL] : '0;
   localparam logic RA_INIT = TABLES_PRESET ? PRESET_BASE[sst_cfg_pkg::RA_BIT] : 1'b0;
   localparam logic [1:0] FMT_INIT = (TABLES_PRESET && MULTI_LEVEL) ?
      PRESET_LAYOUT[sst_cfg_pkg::FMT_LSB +: sst_cfg_pkg::FMT_W] : 2'h0;
   localparam logic [4:0] SPLIT_INIT = (TABLES_PRESET && MULTI_LEVEL) ?
      PRESET_LAYOUT[sst_cfg_pkg::SPLIT_LSB +: sst_cfg_pkg::SPLIT_W] : 5'h00;
   localparam logic [5:0] LOG2_INIT = TABLES_PRESET ?
      PRESET_LAYOUT[sst_cfg_pkg::LOG2_LSB +: sst_cfg_pkg::LOG2_W] : 6'h00;

   // only bits below the output address size exist at all
   logic [PA_W-1:AL] baseAddr_q;
   logic readAlloc_q;
   logic [1:0] format_q;
   logic [4:0] split_q;
   logic [5:0] log2_q;
   logic accessOk;
   logic canWrite;
   logic twoLevel;
   logic [4:0] splitEff;
   logic [5:0] log2Eff;
   logic [PA_W-1:0] rawBase;
   logic [PA_W-1:0] alignedBase;
   logic outOfRange;
   logic [SID_W-1:0] l1Idx;
   logic [SID_W-1:0] l2Idx;
   logic [5:0] l1Count;
   logic [63:0] baseView;
   logic [31:0] layoutView;
   logic [31:0] readWord;
   logic [PA_W-1:0] linAddr;
   logic [PA_W-1:0] twoAddr;
   logic regReadValid_q;
   logic [31:0] regRdata_q;
   logic lookupDone_q;
   logic lookupAbort_q;
   logic badStreamEvent_q;
   logic readAllocHint_q;
   logic twoLevelLookup_q;
   logic [PA_W-1:0] fetchAddr_q;
   logic [SID_W-1:0] l2Index_q;
   logic [5:0] l1CountLog2_q;

   // ------------------------------------------------------------
   // access guard
   // ------------------------------------------------------------
   assign accessOk = regSecure && SECURE_PRESENT;
   // enable and ack both low, so a pending enable still blocks
   assign canWrite = accessOk && !TABLES_PRESET && !translationEnable && !secureEnableAck;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         baseAddr_q <= BASE_INIT;
         readAlloc_q <= RA_INIT;
      end
      else if (regWrite && canWrite && regAddr == sst_cfg_pkg::BASE_LO_OFF)
      begin
         baseAddr_q[31:AL] <= regWdata[31:AL];
      end
      else if (regWrite && canWrite && regAddr == sst_cfg_pkg::BASE_HI_OFF)
      begin
         baseAddr_q[PA_W-1:32] <= regWdata[PA_W-33:0];
         readAlloc_q <= regWdata[sst_cfg_pkg::RA_BIT-32];
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         format_q <= FMT_INIT;
         split_q <= SPLIT_INIT;
         log2_q <= LOG2_INIT;
      end
      else if (regWrite && canWrite && regAddr == sst_cfg_pkg::LAYOUT_OFF)
      begin
         if (MULTI_LEVEL)
         begin
            format_q <= regWdata[sst_cfg_pkg::FMT_LSB +: sst_cfg_pkg::FMT_W];
            split_q <= regWdata[sst_cfg_pkg::SPLIT_LSB +: sst_cfg_pkg::SPLIT_W];
         end
         log2_q <= regWdata[sst_cfg_pkg::LOG2_LSB +: sst_cfg_pkg::LOG2_W];
      end
   end

   // ------------------------------------------------------------
   // effective configuration
   // ------------------------------------------------------------
   assign twoLevel = MULTI_LEVEL && (format_q == sst_cfg_pkg::FMT_TWO_LEVEL);
   always_comb
   begin
      case (split_q)
         sst_cfg_pkg::SPLIT_4K, sst_cfg_pkg::SPLIT_16K, sst_cfg_pkg::SPLIT_64K:
            splitEff = split_q;
         default:
            splitEff = sst_cfg_pkg::SPLIT_4K;
      endcase
   end
   assign log2Eff = (log2_q > SID_W6) ? SID_W6 : log2_q;
   assign rawBase = {baseAddr_q, {AL{1'b0}}};

   sst_base_align #(
      .PA_W(PA_W)
   ) u_align (
      .rawBase(rawBase),
      .log2Raw(log2_q),
      .splitEff(splitEff),
      .twoLevel(twoLevel),
      .alignedBase(alignedBase)
   );

   sst_index_split #(
      .SID_W(SID_W)
   ) u_split (
      .stream_identifier(lookupId),
      .log2Eff(log2Eff),
      .splitEff(splitEff),
      .outOfRange(outOfRange),
      .l1Index(l1Idx),
      .l2Index(l2Idx),
      .l1CountLog2(l1Count)
   );

   // ------------------------------------------------------------
   // readback
   // ------------------------------------------------------------
   always_comb
   begin
      baseView = 64'h0;
      baseView[PA_W-1:AL] = baseAddr_q;
      baseView[sst_cfg_pkg::RA_BIT] = readAlloc_q;
      layoutView = 32'h0;
      layoutView[sst_cfg_pkg::FMT_LSB +: sst_cfg_pkg::FMT_W] = format_q;
      layoutView[sst_cfg_pkg::SPLIT_LSB +: sst_cfg_pkg::SPLIT_W] = split_q;
      layoutView[sst_cfg_pkg::LOG2_LSB +: sst_cfg_pkg::LOG2_W] = log2_q;
      readWord = 32'h0;
      if (accessOk)
      begin
         case (regAddr)
            sst_cfg_pkg::BASE_LO_OFF: readWord = baseView[31:0];
            sst_cfg_pkg::BASE_HI_OFF: readWord = baseView[63:32];
            sst_cfg_pkg::LAYOUT_OFF: readWord = layoutView;
            default: readWord = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         regReadValid_q <= 1'b0;
         regRdata_q <= 32'h0;
      end
      else
      begin
         regReadValid_q <= regRead;
         regRdata_q <= regRead ? readWord : 32'h0;
      end
   end

   // ------------------------------------------------------------
   // lookup
   // ------------------------------------------------------------
   assign linAddr = alignedBase + (PA_W'(lookupId) << sst_cfg_pkg::ENTRY_LOG2);
   assign twoAddr = alignedBase + (PA_W'(l1Idx) << sst_cfg_pkg::DESC_LOG2);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lookupDone_q <= 1'b0;
         lookupAbort_q <= 1'b0;
         badStreamEvent_q <= 1'b0;
         readAllocHint_q <= 1'b0;
         twoLevelLookup_q <= 1'b0;
         fetchAddr_q <= '0;
         l2Index_q <= '0;
         l1CountLog2_q <= 6'h00;
      end
      else
      begin
         lookupDone_q <= lookupValid;
         lookupAbort_q <= lookupValid && outOfRange;
         badStreamEvent_q <= lookupValid && outOfRange && recordInvalidIdEnable;
         if (lookupValid)
         begin
            readAllocHint_q <= readAlloc_q;
            twoLevelLookup_q <= twoLevel;
            // an aborted lookup fetches nothing, so the address is parked at zero
            fetchAddr_q <= outOfRange ? '0 : (twoLevel ? twoAddr : linAddr);
            l2Index_q <= twoLevel ? l2Idx : '0;
            l1CountLog2_q <= twoLevel ? l1Count : 6'h00;
         end
      end
   end

   assign regReadValid = regReadValid_q;
   assign regRdata = regRdata_q;
   assign lookupDone = lookupDone_q;
   assign lookupAbort = lookupAbort_q;
   assign badStreamEvent = badStreamEvent_q;
   assign readAllocHint = readAllocHint_q;
   assign twoLevelLookup = twoLevelLookup_q;
   assign fetchAddr = fetchAddr_q;
   assign l2Index = l2Index_q;
   assign l1CountLog2 = l1CountLog2_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [PA_W-1:0] linMask;
   assign linMask = (PA_W'(1) << ({1'b0, log2_q} + 7'h06)) - PA_W'(1);

   property p_abort_range;
      @(posedge clk) disable iff (!nrst)
      lookupValid && (int'(log2Eff) < SID_W) && ((lookupId >> log2Eff) != '0)
         |=> lookupDone && lookupAbort && fetchAddr == '0;
   endproperty
   a_abort_range: assert property (p_abort_range) else $error("out of range id not aborted");

   property p_event_gate;
      @(posedge clk) disable iff (!nrst)
      badStreamEvent |-> lookupAbort && $past(recordInvalidIdEnable);
   endproperty
   a_event_gate: assert property (p_event_gate) else $error("event without abort or recording");

   property p_guard;
      @(posedge clk) disable iff (!nrst)
      regWrite && (translationEnable || secureEnableAck || !regSecure)
         |=> $stable(baseAddr_q) && $stable(readAlloc_q) && $stable(log2_q) && $stable(format_q);
   endproperty
   a_guard: assert property (p_guard) else $error("guarded register changed");

   property p_nonsecure_read;
      @(posedge clk) disable iff (!nrst)
      regRead && !regSecure |=> regReadValid && regRdata == 32'h0;
   endproperty
   a_nonsecure_read: assert property (p_nonsecure_read) else $error("non-secure read not zero");

   property p_layout_reserved;
      @(posedge clk) disable iff (!nrst)
      regReadValid && $past(regAddr) == sst_cfg_pkg::LAYOUT_OFF
         |-> regRdata[31:18] == 14'h0 && regRdata[15:11] == 5'h00
             && (MULTI_LEVEL || regRdata[17:6] == 12'h000);
   endproperty
   a_layout_reserved: assert property (p_layout_reserved) else $error("reserved layout bits set");

   property p_lin_align;
      @(posedge clk) disable iff (!nrst)
      !twoLevel |-> (alignedBase & linMask) == '0;
   endproperty
   a_lin_align: assert property (p_lin_align) else $error("linear base not aligned");

   // a large first level may legally clear the upper word too, so only small limits are watched
   property p_two_floor;
      @(posedge clk) disable iff (!nrst)
      twoLevel && (int'(log2_q) - int'(splitEff) + 2 < 32)
         |-> alignedBase[5:0] == 6'h00 && alignedBase[PA_W-1:32] == baseAddr_q[PA_W-1:32];
   endproperty
   a_two_floor: assert property (p_two_floor) else $error("two-level base alignment wrong");

   property p_split_legal;
      @(posedge clk) disable iff (!nrst)
      splitEff == 5'h06 || splitEff == 5'h08 || splitEff == 5'h0A;
   endproperty
   a_split_legal: assert property (p_split_legal) else $error("illegal effective split");

   property p_cap;
      @(posedge clk) disable iff (!nrst)
      log2Eff <= SID_W6 && (log2_q <= SID_W6 || log2Eff == SID_W6);
   endproperty
   a_cap: assert property (p_cap) else $error("size not capped");

   property p_bottom_index;
      @(posedge clk) disable iff (!nrst)
      lookupDone && twoLevelLookup |-> (l2Index >> $past(splitEff)) == '0;
   endproperty
   a_bottom_index: assert property (p_bottom_index) else $error("bottom index too wide");

   property p_ra_hint;
      @(posedge clk) disable iff (!nrst)
      lookupValid ##1 lookupDone |-> readAllocHint == $past(readAlloc_q);
   endproperty
   a_ra_hint: assert property (p_ra_hint) else $error("read-alloc hint wrong");

   c_abort_event: cover property (@(posedge clk) disable iff (!nrst) badStreamEvent);
   c_two_level: cover property (@(posedge clk) disable iff (!nrst)
      lookupDone && twoLevelLookup && !lookupAbort);
   c_refused: cover property (@(posedge clk) disable iff (!nrst)
      regWrite && regSecure && translationEnable);
   c_linear: cover property (@(posedge clk) disable iff (!nrst)
      lookupDone && !twoLevelLookup && !lookupAbort);
endmodule // secure_stream_table_config

// *** verilog/sst_base_align.sv ***
// alignment of the programmed table base
`timescale 1ns/10ps
module sst_base_align #(
   parameter int PA_W = 52
) (
   // configuration
   input wire logic [PA_W-1:0] rawBase,
   input wire logic [5:0] log2Raw,
   input wire logic [4:0] splitEff,
   input wire logic twoLevel,
   // result
   output logic [PA_W-1:0] alignedBase
);
   always_comb
   begin
      int limit;
      limit = int'(log2Raw) + sst_cfg_pkg::LIN_ALIGN_EXTRA;
      if (twoLevel)
      begin
         // signed so a split above the size still lands on the 64 byte floor
         limit = int'(log2Raw) - int'(splitEff) - 1 + sst_cfg_pkg::DESC_LOG2;
         if (limit < sst_cfg_pkg::TWO_ALIGN_MIN)
         begin
            limit = sst_cfg_pkg::TWO_ALIGN_MIN;
         end
      end
      for (int i = 0; i < PA_W; i++)
      begin
         alignedBase[i] = rawBase[i] & (i > limit);
      end
   end
endmodule // sst_base_align

// *** verilog/sst_cfg_pkg.sv ***
// constants for the secure stream table configuration block
package sst_cfg_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int REG_ADDR_W = 16;
   localparam logic [15:0] BASE_LO_OFF = 16'h8080;
   localparam logic [15:0] BASE_HI_OFF = 16'h8084;
   localparam logic [15:0] LAYOUT_OFF = 16'h8088;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int RA_BIT = 62;
   localparam int ADDR_LSB = 6;
   localparam int ADDR_MSB = 51;
   localparam int FMT_LSB = 16;
   localparam int FMT_W = 2;
   localparam int SPLIT_LSB = 6;
   localparam int SPLIT_W = 5;
   localparam int LOG2_LSB = 0;
   localparam int LOG2_W = 6;
   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [1:0] FMT_LINEAR = 2'h0;
   localparam logic [1:0] FMT_TWO_LEVEL = 2'h1;
   localparam logic [4:0] SPLIT_4K = 5'h06;
   localparam logic [4:0] SPLIT_16K = 5'h08;
   localparam logic [4:0] SPLIT_64K = 5'h0A;
   // ------------------------------------------------------------
   // geometry and reset values
   // ------------------------------------------------------------
   localparam int ENTRY_LOG2 = 6;
   localparam int DESC_LOG2 = 3;
   localparam int LIN_ALIGN_EXTRA = 5;
   localparam int TWO_ALIGN_MIN = 5;
   localparam logic [63:0] BASE_RESET = 64'h0;
   localparam logic [31:0] LAYOUT_RESET = 32'h0;
endpackage

// *** verilog/sst_index_split.sv ***
// stream identifier range check and level index split
`timescale 1ns/10ps
module sst_index_split #(
   parameter int SID_W = 16
) (
   // inputs
   input wire logic [SID_W-1:0] stream_identifier,
   input wire logic [5:0] log2Eff,
   input wire logic [4:0] splitEff,
   // results
   output logic outOfRange,
   output logic [SID_W-1:0] l1Index,
   output logic [SID_W-1:0] l2Index,
   output logic [5:0] l1CountLog2
);
   // log2Eff is already capped, so a full-width table never rejects
   assign outOfRange = (int'(log2Eff) < SID_W) && ((stream_identifier >> log2Eff) != '0);
   // identifier is in range here, so the shift stops at the size bit
   assign l1Index = stream_identifier >> splitEff;
   assign l2Index = stream_identifier & ~({SID_W{1'b1}} << splitEff);
   assign l1CountLog2 = (log2Eff > {1'b0, splitEff}) ? (log2Eff - {1'b0, splitEff}) : 6'h00;
endmodule // sst_index_split
